//--- hdl/flash_cmd_defs.vh
// Opcodes, phase lengths and timing counts of the serial flash command front end
`ifndef FLASH_CMD_DEFS_VH
`define FLASH_CMD_DEFS_VH
`define OP_READ 8'h03
`define OP_FAST_ARRAY_READ 8'h0B
`define OP_DUAL_OUT_READ 8'h3B
`define OP_DUAL_ADDR_DATA_READ 8'hBB
`define OP_QUAD_OUT_READ 8'h6B
`define OP_QUAD_ADDR_DATA_READ 8'hEB
`define OP_QUAD_WORD_READ 8'hE7
`define OP_PAGE_ERASE 8'h81
`define OP_SECTOR_ERASE 8'h20
`define OP_HALF_BLOCK_ERASE 8'h52
`define OP_BLOCK_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_PAGE_PROGRAM 8'h02
`define OP_QUAD_PAGE_PROGRAM 8'h32
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_WRITE_LATCH_SET 8'h06
`define OP_WRITE_LATCH_CLEAR 8'h04
`define OP_VOLATILE_WRITE_ENABLE 8'h50
`define OP_SINGLE_BLOCK_LOCK 8'h36
`define OP_SINGLE_BLOCK_UNLOCK 8'h39
`define OP_LOCK_STATE_READ 8'h3D
`define OP_ALL_BLOCKS_LOCK 8'h7E
`define OP_ALL_BLOCKS_UNLOCK 8'h98
`define OP_SECURE_AREA_ERASE 8'h44
`define OP_SECURE_AREA_PROGRAM 8'h42
`define OP_SECURE_AREA_READ 8'h48
`define OP_STATUS_FIRST_READ 8'h05
`define OP_STATUS_SECOND_READ 8'h35
`define OP_CONFIG_READ 8'h15
`define OP_STATUS_WRITE 8'h01
`define OP_STATUS_SECOND_WRITE 8'h31
`define OP_CONFIG_WRITE 8'h11
`define OP_BUFFER_CLEAR 8'h9E
`define OP_BUFFER_LOAD 8'h9A
`define OP_BUFFER_READ 8'h9B
`define OP_BUFFER_WRITE 8'h9C
`define OP_BUFFER_COMMIT 8'h9D
`define OP_DEEP_SLEEP_ENTRY 8'hB9
`define OP_DEEP_SLEEP_EXIT_ID 8'hAB
`define OP_IDENTITY_READ 8'h9F
`define OP_MAKER_DEVICE_READ 8'h90
`define OP_MAKER_DEVICE_READ_X2 8'h92
`define OP_MAKER_DEVICE_READ_X4 8'h94
`define OP_UNIQUE_SERIAL_READ 8'h4B
`define OP_BURST_LENGTH_SET 8'h77
`define OP_PARAM_TABLE_READ 8'h5A
`define OP_FOUR_LINE_CMD_ENTRY 8'h38
`define OP_RELEASE_ENHANCED 8'hFF
`define OP_RESET_ARM 8'h66
`define OP_RESET 8'h99
`define ADDR_BYTES 2'h3
`define RESET_TIME_NS 30000
`define CLK_PERIOD_NS 25
`define RESET_CYCLES ((`RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_REJECT 3'h7
`endif

//--- hdl/serial_flash_cmd_front_end.v
// Serial flash command front end: opcode decode, phase sequencing, hold pause
// Behaviour
// R01 - Hold starts on hold pin fall with chip select low, deferred until clock low
// R02 - Hold ends on hold pin rise, deferred until clock low
// R03 - Hold pauses only serial traffic; internal program or erase keeps running
// R04 - Data output is high impedance from hold pin fall until its rise
// R05 - Serial input ignored during hold until clock low and hold pin high
// R06 - Chip select rising during hold resets the interface logic
// R07 - In quad operation hold is disabled and the pin is a data line
// R08 - 03h takes three address bytes; 0Bh adds one dummy; both stream data
// R09 - 3Bh one dummy, dual data; BBh dual address, one or two dummies
// R10 - 6Bh one dummy; EBh three or five dummy cycles; E7h one; all stream
// R11 - Erase opcodes take three address bytes; chip erase takes none
// R12 - 02h and 32h take address then data; 32h data on four lines
// R13 - 75h suspends and 7Ah resumes program or erase, no address
// R14 - 06h sets, 04h clears write latch; 50h volatile status write enable
// R15 - 36h, 39h, 3Dh take an address; 7Eh and 98h take none
// R16 - 44h, 42h with data, 48h with one dummy each take an address
// R17 - 05h, 35h, 15h return one register byte with no address
// R18 - 01h takes two bytes or one on variant; 31h variant only; 11h one byte
// R19 - Buffer clear without address; load, read, write, commit take an address
// R20 - B9h enters deep sleep; ABh exits and returns an ID after address
// R21 - 9Fh returns three ID bytes; 90h, 92h, 94h return maker and device ID
// R22 - Also decode 4Bh, 77h, 5Ah, 38h and FFh
// R23 - Reset arm then reset; device busy for 30 us accepting no command
// R24 - Inputs sampled on clock rise, outputs shifted on clock fall
// R25 - Write class commands execute only when chip select rises on a byte boundary
// R26 - Quad commands only with quad enable bit set; hold pin then a data line
`default_nettype none
`include "flash_cmd_defs.vh"
module serial_flash_cmd_front_end #(
  parameter RESET_CYCLES = `RESET_CYCLES,
  parameter ORDER_VARIANT_D = 0,
  parameter EXTRA_DUMMY_2IO = 0,
  parameter EXTRA_DUMMY_4IO = 0
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire cs_b_i,
  input wire sclk_i,
  input wire [3:0] io_i,
  output reg [3:0] io_o,
  output reg [3:0] io_oe_o,
  input wire quad_enable_bit_i,
  input wire op_busy_i,
  input wire [7:0] rd_data_i,
  output reg [7:0] opcode_o,
  output reg [23:0] addr_o,
  output reg cmd_exec_o,
  output reg [7:0] wr_data_o,
  output reg wr_data_valid_o,
  output reg rd_data_req_o,
  output reg hold_active_o,
  output reg reset_busy_o,
  output reg write_latch_o,
  output reg deep_sleep_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_DUMMY = 3'h3;
  localparam ST_DIN = 3'h4;
  localparam ST_DOUT = 3'h5;
  localparam ST_DONE = 3'h6;
  localparam ST_REJECT = `CMD_REJECT;
  // Decode: {valid, addr, dummy cycles(5), data dir(2: 0 none,1 in,2 out), lines(3)}
  function [11:0] decode;
    input [7:0] op;
    input qe;
    begin
      case (op)
        `OP_READ: decode = {1'b1, 1'b1, 5'd0, 2'd2, 3'd1}; // [R08]
        `OP_FAST_ARRAY_READ: decode = {1'b1, 1'b1, 5'd8, 2'd2, 3'd1}; // [R08]
        `OP_DUAL_OUT_READ: decode = {1'b1, 1'b1, 5'd8, 2'd2, 3'd2}; // [R09]
        `OP_DUAL_ADDR_DATA_READ: decode = {1'b1, 1'b1, EXTRA_DUMMY_2IO ? 5'd8 : 5'd4, 2'd2, 3'd2}; // [R09]
        `OP_QUAD_OUT_READ: decode = {qe, 1'b1, 5'd8, 2'd2, 3'd4}; // [R10] [R26]
        `OP_QUAD_ADDR_DATA_READ: decode = {qe, 1'b1, EXTRA_DUMMY_4IO ? 5'd5 : 5'd3, 2'd2, 3'd4}; // [R10] [R26]
        `OP_QUAD_WORD_READ: decode = {qe, 1'b1, 5'd2, 2'd2, 3'd4}; // [R10] [R26]
        `OP_PAGE_ERASE, `OP_SECTOR_ERASE, `OP_HALF_BLOCK_ERASE, `OP_BLOCK_ERASE,
        `OP_SINGLE_BLOCK_LOCK, `OP_SINGLE_BLOCK_UNLOCK, `OP_LOCK_STATE_READ,
        `OP_SECURE_AREA_ERASE, `OP_BUFFER_LOAD, `OP_BUFFER_COMMIT:
          decode = {1'b1, 1'b1, 5'd0, 2'd0, 3'd1}; // [R11] [R15] [R16] [R19]
        `OP_PAGE_PROGRAM, `OP_SECURE_AREA_PROGRAM, `OP_BUFFER_WRITE:
          decode = {1'b1, 1'b1, 5'd0, 2'd1, 3'd1}; // [R12] [R16] [R19]
        `OP_QUAD_PAGE_PROGRAM: decode = {qe, 1'b1, 5'd0, 2'd1, 3'd4}; // [R12] [R26]
        `OP_SECURE_AREA_READ, `OP_BUFFER_READ: decode = {1'b1, 1'b1, 5'd8, 2'd2, 3'd1}; // [R16] [R19]
        `OP_MAKER_DEVICE_READ, `OP_DEEP_SLEEP_EXIT_ID: decode = {1'b1, 1'b1, 5'd0, 2'd2, 3'd1}; // [R20] [R21]
        `OP_MAKER_DEVICE_READ_X2: decode = {1'b1, 1'b1, 5'd4, 2'd2, 3'd2}; // [R21]
        `OP_MAKER_DEVICE_READ_X4: decode = {qe, 1'b1, 5'd2, 2'd2, 3'd4}; // [R21] [R26]
        `OP_STATUS_FIRST_READ, `OP_STATUS_SECOND_READ, `OP_CONFIG_READ, `OP_IDENTITY_READ:
          decode = {1'b1, 1'b0, 5'd0, 2'd2, 3'd1}; // [R17] [R21]
        `OP_STATUS_WRITE, `OP_CONFIG_WRITE: decode = {1'b1, 1'b0, 5'd0, 2'd1, 3'd1}; // [R18]
        `OP_STATUS_SECOND_WRITE: decode = {ORDER_VARIANT_D != 0, 1'b0, 5'd0, 2'd1, 3'd1}; // [R18]
        `OP_UNIQUE_SERIAL_READ: decode = {1'b1, 1'b0, 5'd31, 2'd2, 3'd1}; // [R22]
        `OP_PARAM_TABLE_READ: decode = {1'b1, 1'b1, 5'd8, 2'd2, 3'd1}; // [R22]
        `OP_FOUR_LINE_CMD_ENTRY: decode = {qe, 1'b0, 5'd0, 2'd0, 3'd1}; // [R22] [R26]
        `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B, `OP_SUSPEND, `OP_RESUME, `OP_WRITE_LATCH_SET,
        `OP_WRITE_LATCH_CLEAR, `OP_VOLATILE_WRITE_ENABLE, `OP_ALL_BLOCKS_LOCK,
        `OP_ALL_BLOCKS_UNLOCK, `OP_BUFFER_CLEAR, `OP_DEEP_SLEEP_ENTRY, `OP_BURST_LENGTH_SET,
        `OP_RELEASE_ENHANCED, `OP_RESET_ARM, `OP_RESET:
          decode = {1'b1, 1'b0, 5'd0, 2'd0, 3'd1}; // [R11] [R13] [R14] [R15] [R19] [R20] [R22] [R23]
        default: decode = 12'h000;
      endcase
    end
  endfunction
  // Commands that must end exactly on a byte boundary
  function boundary_cmd;
    input [7:0] op;
    begin
      case (op)
        `OP_WRITE_LATCH_SET, `OP_WRITE_LATCH_CLEAR, `OP_STATUS_WRITE, `OP_PAGE_ERASE,
        `OP_SECTOR_ERASE, `OP_HALF_BLOCK_ERASE, `OP_BLOCK_ERASE, `OP_CHIP_ERASE_A,
        `OP_CHIP_ERASE_B, `OP_PAGE_PROGRAM, `OP_QUAD_PAGE_PROGRAM, `OP_DEEP_SLEEP_ENTRY,
        `OP_SECURE_AREA_ERASE, `OP_SECURE_AREA_PROGRAM, `OP_SUSPEND, `OP_RESUME,
        `OP_RESET_ARM, `OP_RESET: boundary_cmd = 1'b1;
        default: boundary_cmd = 1'b0;
      endcase
    end
  endfunction
  // Two-flop synchronisers for the pins
  reg [6:0] sync_a;
  reg [6:0] sync_b;
  reg sclk_prev;
  reg hold_pin_prev;
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_a <= 7'h5e;
      sync_b <= 7'h5e;
      sclk_prev <= 1'b0;
      hold_pin_prev <= 1'b1;
    end else begin
      sync_a <= {cs_b_i, sclk_i, io_i, quad_enable_bit_i};
      sync_b <= sync_a;
      sclk_prev <= sync_b[5];
      hold_pin_prev <= sync_b[4];
    end
  end
  wire cs_b_s = sync_b[6];
  wire sclk_s = sync_b[5];
  wire [3:0] io_s = sync_b[4:1];
  wire qe_s = sync_b[0];
  wire sclk_rise = sclk_s && !sclk_prev;
  wire sclk_fall = !sclk_s && sclk_prev;
  reg [2:0] state;
  reg [2:0] lines;
  reg [1:0] dir;
  reg [4:0] dummy_left;
  reg [4:0] bit_cnt;
  reg [1:0] addr_left;
  reg [7:0] shreg;
  reg [7:0] out_sh;
  reg hold;
  reg hold_arm;
  reg rst_armed;
  reg [15:0] rst_cnt;
  reg [11:0] dec;
  reg [7:0] next_shreg;
  wire hold_en = !qe_s && !(lines == 3'd4 && state != ST_CMD); // [R07] [R26]
  wire cs_active = !cs_b_s && !reset_busy_o;
  wire [11:0] op_dec = decode(opcode_o, qe_s);
  wire [7:0] out_byte = bit_cnt == 5'd0 ? rd_data_i : out_sh;
  always @* begin
    case (lines)
      3'd2: next_shreg = {shreg[5:0], io_s[1:0]};
      3'd4: next_shreg = {shreg[3:0], io_s};
      default: next_shreg = {shreg[6:0], io_s[0]};
    endcase
    dec = decode(next_shreg, qe_s);
  end
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      lines <= 3'd1;
      dir <= 2'd0;
      dummy_left <= 5'd0;
      bit_cnt <= 5'd0;
      addr_left <= 2'd0;
      shreg <= 8'h00;
      out_sh <= 8'h00;
      hold <= 1'b0;
      hold_arm <= 1'b0;
      rst_armed <= 1'b0;
      rst_cnt <= 16'h0000;
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
      opcode_o <= 8'h00;
      addr_o <= 24'h00_0000;
      cmd_exec_o <= 1'b0;
      wr_data_o <= 8'h00;
      wr_data_valid_o <= 1'b0;
      rd_data_req_o <= 1'b0;
      hold_active_o <= 1'b0;
      reset_busy_o <= 1'b0;
      write_latch_o <= 1'b0;
      deep_sleep_o <= 1'b0;
    end else begin
      cmd_exec_o <= 1'b0;
      wr_data_valid_o <= 1'b0;
      rd_data_req_o <= 1'b0;
      hold_active_o <= hold;
      if (reset_busy_o) begin
        if (rst_cnt == 16'h0001)
          reset_busy_o <= 1'b0;
        rst_cnt <= rst_cnt - 16'h0001; // [R23]
      end
      // Hold: request on pin fall, takes effect with clock low
      if (!hold_en || cs_b_s) begin
        hold_arm <= 1'b0;
      end else if (!io_s[3] && hold_pin_prev) begin
        hold_arm <= 1'b1;
      end else if (io_s[3] && !hold_pin_prev) begin
        hold_arm <= 1'b0;
      end
      if (!hold_en) begin
        hold <= 1'b0;
      end else if (!hold && (hold_arm || (!io_s[3] && hold_pin_prev)) && !sclk_s && !cs_b_s) begin
        hold <= 1'b1; // [R01]
        io_oe_o <= 4'h0; // [R04]
      end else if (hold && io_s[3] && !sclk_s) begin
        hold <= 1'b0; // [R02]
      end
      if (cs_b_s) begin
        // Chip select high ends the frame; write class needs a whole byte
        if (state == ST_DONE || ((state == ST_DIN || state == ST_CMD) && bit_cnt == 5'd0
            && state != ST_CMD) || (state == ST_DIN && bit_cnt == 5'd0)) begin
          if (!hold && (!boundary_cmd(opcode_o) || bit_cnt == 5'd0)) begin // [R06] [R25]
            cmd_exec_o <= 1'b1; // [R03]
            case (opcode_o)
              `OP_WRITE_LATCH_SET: write_latch_o <= 1'b1; // [R14]
              `OP_WRITE_LATCH_CLEAR: write_latch_o <= 1'b0; // [R14]
              `OP_DEEP_SLEEP_ENTRY: deep_sleep_o <= 1'b1; // [R20]
              `OP_RESET: begin
                if (rst_armed) begin
                  reset_busy_o <= 1'b1; // [R23]
                  rst_cnt <= RESET_CYCLES[15:0];
                  write_latch_o <= 1'b0;
                end
              end
              default: ;
            endcase
            rst_armed <= opcode_o == `OP_RESET_ARM;
          end
        end
        state <= ST_IDLE;
        hold <= 1'b0; // [R06]
        io_oe_o <= 4'h0;
        lines <= 3'd1;
        bit_cnt <= 5'd0;
      end else if (state == ST_IDLE) begin
        // Busy with a reset: sit out the whole frame [R23]
        state <= cs_active ? ST_CMD : ST_REJECT;
        bit_cnt <= 5'd0;
      end else if (sclk_rise && !hold && (!hold_pin_prev ? 1'b0 : 1'b1) || (sclk_rise && !hold_en)) begin
        // Bits taken on clock rise [R24] [R05]
        shreg <= next_shreg;
        bit_cnt <= bit_cnt + {2'b00, lines};
        case (state)
          ST_CMD: if (bit_cnt == 5'd7) begin
            bit_cnt <= 5'd0;
            opcode_o <= next_shreg;
            if (opcode_o != `OP_RESET_ARM || next_shreg != `OP_RESET)
              rst_armed <= rst_armed && next_shreg == `OP_RESET;
            if (!dec[11] || (deep_sleep_o && next_shreg != `OP_DEEP_SLEEP_EXIT_ID)) begin
              state <= ST_REJECT; // Unknown or disabled opcode: standby until next frame
              opcode_o <= 8'h00;
            end else begin
              if (next_shreg == `OP_DEEP_SLEEP_EXIT_ID)
                deep_sleep_o <= 1'b0; // [R20]
              dir <= dec[4:3];
              dummy_left <= dec[9:5];
              addr_left <= `ADDR_BYTES;
              lines <= (next_shreg == `OP_DUAL_ADDR_DATA_READ || next_shreg == `OP_QUAD_ADDR_DATA_READ ||
                next_shreg == `OP_QUAD_WORD_READ) ? dec[2:0] : 3'd1;
              state <= dec[10] ? ST_ADDR : (dec[4:3] == 2'd2 ? ST_DOUT : (dec[4:3] == 2'd1 ? ST_DIN : ST_DONE));
              if (dec[4:3] == 2'd2 && !dec[10]) begin
                lines <= dec[2:0];
                state <= dec[9:5] != 5'd0 ? ST_DUMMY : ST_DOUT;
              end
            end
          end
          ST_ADDR: if (bit_cnt + {2'b00, lines} >= 5'd8) begin
            bit_cnt <= 5'd0;
            addr_o <= {addr_o[15:0], next_shreg};
            addr_left <= addr_left - 2'd1;
            if (addr_left == 2'd1) begin
              lines <= (opcode_o == `OP_QUAD_PAGE_PROGRAM || dir == 2'd2) ? op_dec[2:0] : 3'd1;
              state <= dummy_left != 5'd0 ? ST_DUMMY : (dir == 2'd2 ? ST_DOUT : (dir == 2'd1 ? ST_DIN : ST_DONE));
            end
          end
          ST_DUMMY: begin
            bit_cnt <= 5'd0;
            dummy_left <= dummy_left - 5'd1;
            if (dummy_left == 5'd1)
              state <= ST_DOUT;
          end
          ST_DIN: if (bit_cnt + {2'b00, lines} >= 5'd8) begin
            bit_cnt <= 5'd0;
            wr_data_o <= next_shreg; // [R12] [R18]
            wr_data_valid_o <= 1'b1;
          end
          ST_DOUT: bit_cnt <= bit_cnt; // Output side counts bits on the fall
          default: ;
        endcase
      end else if (sclk_fall && !hold && !hold_arm && state == ST_DOUT) begin
        // Output shifted on clock fall [R24]
        if (bit_cnt == 5'd0) begin
          out_sh <= rd_data_i;
          rd_data_req_o <= 1'b1;
        end
        io_oe_o <= lines == 3'd4 ? 4'hf : (lines == 3'd2 ? 4'h3 : 4'h2);
        case (lines)
          3'd4: begin
            io_o <= bit_cnt == 5'd0 ? rd_data_i[7:4] : out_sh[3:0];
            bit_cnt <= bit_cnt == 5'd4 ? 5'd0 : 5'd4;
          end
          3'd2: begin
            io_o <= {2'b00, out_byte[3'd7 - bit_cnt[2:0]], out_byte[3'd6 - bit_cnt[2:0]]};
            bit_cnt <= bit_cnt == 5'd6 ? 5'd0 : bit_cnt + 5'd2;
          end
          default: begin
            io_o <= {2'b00, (bit_cnt == 5'd0 ? rd_data_i[7] : out_sh[3'd7 - bit_cnt[2:0]]), 1'b0};
            bit_cnt <= bit_cnt == 5'd7 ? 5'd0 : bit_cnt + 5'd1;
          end
        endcase
      end
      if (hold_en && !cs_b_s && !io_s[3] && (hold || hold_arm || hold_pin_prev))
        io_oe_o <= 4'h0; // [R04]
    end
  end
endmodule // serial_flash_cmd_front_end
`default_nettype wire

//--- tb/front_end_monitor.sv
// Assertion checker bound to the serial flash command front end
`default_nettype none
module front_end_monitor #(
  parameter RESET_CYCLES = 1200
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  input wire logic [3:0] io_oe_o,
  input wire logic quad_enable_bit_i,
  input wire logic [7:0] opcode_o,
  input wire logic cmd_exec_o,
  input wire logic hold_active_o,
  input wire logic reset_busy_o,
  input wire logic write_latch_o,
  input wire logic deep_sleep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int busy_cnt;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Length of the current reset busy stretch
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) busy_cnt <= 0;
    else busy_cnt <= reset_busy_o ? busy_cnt + 1 : 0;
  end
  hold_needs_cs_a: assert property ($rose(hold_active_o) |-> !$past(cs_b_i) && !$past(io_i[3]))
    else $error("hold began without select and hold pin low");
  hold_clk_low_a: assert property ($changed(hold_active_o) |-> !$past(sclk_i))
    else $error("hold changed while serial clock high");
  hold_hiz_a: assert property (hold_active_o && $past(hold_active_o) |-> io_oe_o == 4'h0)
    else $error("output driven during hold");
  quad_no_hold_a: assert property (quad_enable_bit_i [*6] |-> !hold_active_o)
    else $error("hold active in quad mode");
  cs_clears_hold_a: assert property (cs_b_i [*5] |-> !hold_active_o)
    else $error("hold kept with select high");
  busy_len_a: assert property ($fell(reset_busy_o) |-> busy_cnt == RESET_CYCLES)
    else $error("reset busy length wrong");
  busy_refuse_a: assert property (reset_busy_o && $past(reset_busy_o) |-> !cmd_exec_o)
    else $error("command accepted while resetting");
  latch_set_a: assert property ($rose(write_latch_o) |-> opcode_o == 8'h06)
    else $error("write latch set by wrong opcode");
  sleep_entry_a: assert property ($rose(deep_sleep_o) |-> opcode_o == 8'hB9)
    else $error("deep sleep by wrong opcode");
  exec_frame_end_a: assert property (cmd_exec_o |-> cs_b_i && $past(cs_b_i, 2))
    else $error("command accepted inside a frame");
  quad_refuse_a: assert property (cmd_exec_o && !$past(quad_enable_bit_i, 8) |-> opcode_o != 8'h32)
    else $error("quad command accepted without quad enable");
  cover property ($rose(hold_active_o));
  cover property ($fell(reset_busy_o));
  cover property ($rose(deep_sleep_o));
endmodule // front_end_monitor
bind serial_flash_cmd_front_end front_end_monitor #(.RESET_CYCLES(RESET_CYCLES)) front_end_monitor_i (
  .clk_sys_i, .rst_b_i, .cs_b_i, .sclk_i, .io_i, .io_oe_o, .quad_enable_bit_i,
  .opcode_o, .cmd_exec_o, .hold_active_o, .reset_busy_o, .write_latch_o, .deep_sleep_o);
`default_nettype wire

//--- tb/flash_host.sv
// Host controller model: chip select, serial clock, data and hold pins
`default_nettype none
module flash_host (
  input wire logic clk_i,
  input wire logic [3:0] pin_i,
  output logic cs_b_o,
  output logic sclk_o,
  output logic [3:0] pin_o,
  output logic [3:0] pin_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    pin_o = 4'h8;
    pin_en_o = 4'h9;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start();
    tick(1);
    cs_b_o = 1'b0;
    tick(4);
  endtask
  task automatic stop();
    tick(4);
    cs_b_o = 1'b1;
    tick(12);
  endtask
  task automatic pins(input logic s, input logic h);
    sclk_o = s;
    pin_o[3] = h; // hold pin set along with the clock, whatever the chip select
    tick(8);
  endtask
  // Clock idles low; data changes while it is low
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      pin_o[0] = tx[i];
      tick(4);
      sclk_o = 1'b1;
      rx[i] = pin_i[1];
      tick(4);
      sclk_o = 1'b0;
    end
  endtask
endmodule // flash_host
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the serial flash command front end
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BUSY = 200;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic quad_enable_bit_i = 1'b0;
  logic flt = 1'b0;
  logic op_busy_i = 1'b0;
  logic [7:0] rd_data_i = 8'hA5;
  wire logic cs_b_i, sclk_i, cmd_exec_o, wr_data_valid_o, rd_data_req_o;
  wire logic hold_active_o, reset_busy_o, write_latch_o, deep_sleep_o;
  wire logic [3:0] io_i, io_o, io_oe_o, host_pin, host_en;
  wire logic [7:0] opcode_o, wr_data_o;
  wire logic [23:0] addr_o;
  int failures = 0;
  int comparisons = 0;
  int execs = 0;
  int reqs = 0;
  int got;
  logic [7:0] rx, last_wr;
  logic [7:0] ops [19] = '{8'h60, 8'hC7, 8'h75, 8'h7A, 8'h7E, 8'h98, 8'h9E, 8'h77, 8'hFF,
    8'h81, 8'h20, 8'h52, 8'hD8, 8'h36, 8'h39, 8'h44, 8'h9A, 8'h9D, 8'h3D};
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) flt <= ~flt;
  always @(posedge clk_sys_i) if (cmd_exec_o) execs <= execs + 1;
  always @(posedge clk_sys_i) if (rd_data_req_o) reqs <= reqs + 1;
  always @(posedge clk_sys_i) if (wr_data_valid_o) last_wr <= wr_data_o;
  // Undriven lines show a changing pattern
  assign io_i = (io_oe_o & io_o) | (~io_oe_o & host_en & host_pin) | (~io_oe_o & ~host_en & {4{flt}});
  serial_flash_cmd_front_end #(.RESET_CYCLES(BUSY)) serial_flash_cmd_front_end_i (
    .clk_sys_i, .rst_b_i, .cs_b_i, .sclk_i, .io_i, .io_o, .io_oe_o, .quad_enable_bit_i, .op_busy_i,
    .rd_data_i, .opcode_o, .addr_o, .cmd_exec_o, .wr_data_o, .wr_data_valid_o, .rd_data_req_o,
    .hold_active_o, .reset_busy_o, .write_latch_o, .deep_sleep_o);
  flash_host flash_host_i (.clk_i(clk_sys_i), .pin_i(io_i), .cs_b_o(cs_b_i), .sclk_o(sclk_i),
    .pin_o(host_pin), .pin_en_o(host_en));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole frame: opcode, address bytes, data bytes, stray bits
  task automatic frame(input logic [7:0] op, input int nadr, input int ndata, input int extra);
    int n;
    n = execs;
    flash_host_i.start();
    flash_host_i.xfer(op, 8, rx);
    for (int i = 0; i < nadr; i++) flash_host_i.xfer(8'h12 + 8'h22 * i[7:0], 8, rx);
    for (int i = 0; i < ndata; i++) flash_host_i.xfer(8'h3C, 8, rx);
    if (extra > 0) flash_host_i.xfer(8'h00, extra, rx);
    flash_host_i.stop();
    got = execs - n;
  endtask
  task automatic t_latch();
    frame(8'h06, 0, 0, 0);
    check("latch set", write_latch_o, 1);
    frame(8'h50, 0, 0, 0);
    check("volatile exec", got, 1);
    frame(8'h04, 0, 0, 0);
    check("latch clear", write_latch_o, 0);
  endtask
  task automatic t_tables();
    for (int i = 0; i < 19; i++) begin
      frame(ops[i], (i < 9) ? 0 : 3, 0, 0);
      check("exec", got, 1);
      check("opcode", opcode_o, ops[i]);
      if (i >= 9) check("addr", addr_o, 24'h12_3456);
    end
  endtask
  task automatic t_read();
    int r;
    r = reqs;
    frame(8'h03, 3, 1, 0);
    check("read data", rx, 8'hA5);
    check("byte loads", reqs - r, 2);
    check("read addr", addr_o, 24'h12_3456);
    frame(8'h0B, 4, 1, 0);
    check("fast data", rx, 8'hA5);
    frame(8'h05, 0, 1, 0);
    check("status", rx, 8'hA5);
    frame(8'h15, 0, 1, 0);
    check("config", rx, 8'hA5);
    frame(8'h9F, 0, 1, 0);
    check("identity", rx, 8'hA5);
    frame(8'h3B, 4, 0, 4);
    check("dual data", rx, 8'hC0);
  endtask
  task automatic t_program();
    frame(8'h06, 0, 0, 0);
    frame(8'h02, 3, 1, 0);
    check("program exec", got, 1);
    check("program data", last_wr, 8'h3C);
    frame(8'h01, 0, 2, 0);
    check("status write", got, 1);
    frame(8'h31, 0, 1, 0);
    check("variant only", got, 0);
    frame(8'h06, 0, 0, 0);
    frame(8'h20, 3, 0, 3);
    check("off boundary", got, 0);
  endtask
  task automatic t_sleep();
    frame(8'hB9, 0, 0, 0);
    check("sleep", deep_sleep_o, 1);
    frame(8'hAB, 3, 1, 0);
    check("wake", deep_sleep_o, 0);
  endtask
  task automatic t_hold();
    flash_host_i.start();
    flash_host_i.xfer(8'h03, 8, rx);
    for (int i = 0; i < 3; i++) flash_host_i.xfer(8'h00, 8, rx);
    flash_host_i.xfer(8'h00, 4, rx);
    check("data before hold", rx, 8'hA0);
    check("drive before hold", io_oe_o, 4'h2);
    flash_host_i.pins(1'b1, 1'b0);
    check("hold deferred", hold_active_o, 0);
    check("hold hiz early", io_oe_o, 0);
    flash_host_i.pins(1'b0, 1'b0);
    check("hold on", hold_active_o, 1);
    flash_host_i.pins(1'b1, 1'b1);
    check("end deferred", hold_active_o, 1);
    check("hold hiz", io_oe_o, 0);
    flash_host_i.pins(1'b0, 1'b1);
    check("hold off", hold_active_o, 0);
    flash_host_i.stop();
  endtask
  task automatic t_hold_cs();
    flash_host_i.start();
    flash_host_i.xfer(8'h03, 8, rx);
    flash_host_i.pins(1'b0, 1'b0);
    flash_host_i.stop();
    check("cs ends hold", hold_active_o, 0);
    flash_host_i.pins(1'b0, 1'b1);
    frame(8'h06, 0, 0, 0);
    check("restart", got, 1);
  endtask
  task automatic t_quad();
    frame(8'h32, 3, 1, 0);
    check("quad refused", got, 0);
    quad_enable_bit_i = 1'b1;
    frame(8'h06, 0, 0, 0);
    frame(8'h32, 3, 1, 0);
    check("quad program", got, 1);
    flash_host_i.start();
    flash_host_i.pins(1'b0, 1'b0);
    check("no hold quad", hold_active_o, 0);
    flash_host_i.pins(1'b0, 1'b1);
    flash_host_i.stop();
    quad_enable_bit_i = 1'b0;
  endtask
  task automatic t_reset();
    frame(8'h66, 0, 0, 0);
    frame(8'h06, 0, 0, 0);
    frame(8'h99, 0, 0, 0);
    check("split reset", reset_busy_o, 0);
    frame(8'h66, 0, 0, 0);
    frame(8'h99, 0, 0, 0);
    check("reset busy", reset_busy_o, 1);
    frame(8'h04, 0, 0, 0);
    check("busy refuse", got, 0);
    for (int k = 0; k < 400 && reset_busy_o === 1'b1; k++) flash_host_i.tick(1);
    check("busy ends", reset_busy_o, 0);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys_i);
    check("reset outputs", {opcode_o, cmd_exec_o, hold_active_o, reset_busy_o, write_latch_o, io_oe_o}, 0);
    repeat (5) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_latch();
    t_tables();
    t_read();
    t_program();
    t_sleep();
    t_hold();
    t_hold_cs();
    t_quad();
    t_reset();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
